// file: rtl/ppm_port_ctrl.sv
// parallel port mode control: apb registers, master sequencer, slave port
//
// Notes on behaviour
// - busy bit reads one during master transfers
// - irq select 00 none, 01 each cycle
// - irq select 10 on buffer three access
// - step 01 increments address bits 10:2, 14
// - step 10 decrements; step 00 holds address
// - step 11 auto-increments legacy slave buffer pointers
// - address bit 14 kept when used as select
// - mode 11 master with direction, enable strobes
// - mode 10 master with separate read, write
// - mode 01 slave addressed by two lines
// - mode 00 legacy slave, no address lines
// - setup phase lasts setup select plus one
// - strobe lasts strobe select plus one periods
// - strobe select zero forces short setup, hold
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module ppm_port_ctrl
  import ppm_pkg::*;
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // apb slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // interrupt
  output logic                 irq,
  // port pins
  input  wire ppm_pin_in_type  pins_in,
  output ppm_pin_out_type      pins_out
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  ppm_pin_in_type  sync1_reg, sync2_reg, sync3_reg, flt_reg;
  ppm_mode_type    mode_reg, mode_rd;
  ppm_state_type   state_reg;
  ppm_pin_out_type pins_reg;
  logic [15:0]     addr_reg;
  logic [3:0]      cnt_reg, setup_cnt, hold_len;
  logic [4:0]      strb_len_reg;
  logic [7:0]      wdata_reg, rdata_reg;
  logic [7:0]      wbuf_mem [BUF_COUNT];
  logic [7:0]      rbuf_mem [BUF_COUNT];
  logic [1:0]      wptr_reg, rptr_reg, widx, ridx;
  logic [31:0]     rd_mux;
  logic            is_read_reg, cs14_reg, stat_reg, mask_reg;
  logic            host_wr_prev_reg, host_rd_prev_reg;
  logic            acc_wr, acc_setup, hit, busy, go, go_wr, go_rd;
  logic            sel_mode, sel_addr, sel_data, sel_stat, sel_mask;
  logic            sel_ctrl, sel_buf, master_on, slave_on, fast;
  logic            host_wr, host_rd, wr_rise, rd_fall, xfer_end, irq_set;

  // slave buffer index from mode, step select and pointer
  function automatic logic [1:0] slv_index(input logic [1:0] ptr,
                                           input ppm_mode_type m,
                                           input logic [1:0] a);
    logic [1:0] r;
    r = '0;
    if (m.port_mode == PM_ENH) begin
      r = a;
    end else if (m.address_step_select == STEP_BUF) begin
      r = ptr;
    end
    return r;
  endfunction : slv_index

  // master address step over bits 10:2 and 14
  function automatic logic [15:0] ppm_step(input logic [15:0] a,
                                           input logic [1:0] step,
                                           input logic keep14);
    logic [9:0]  seq;
    logic [15:0] r;
    seq = {a[A14_BIT], a[ASTEP_HI:ASTEP_LO]};
    if (step == STEP_INC) begin
      seq = seq + 10'h001;
    end else if (step == STEP_DEC) begin
      seq = seq - 10'h001;
    end
    r = a;
    r[ASTEP_HI:ASTEP_LO] = seq[8:0];
    if (!keep14) begin
      r[A14_BIT] = seq[9];
    end
    return r;
  endfunction : ppm_step

  // ----------------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------------
  // three stage chain on every pin input
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else begin
      sync1_reg <= pins_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // a bit changes once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_reg <= '0;
    end else begin
      flt_reg <= ppm_pin_in_type'((sync3_reg & ~(sync2_reg ^ sync3_reg))
                                | (flt_reg & (sync2_reg ^ sync3_reg)));
    end
  end

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  assign sel_mode  = (paddr == OFS_MODE);
  assign sel_addr  = (paddr == OFS_ADDR);
  assign sel_data  = (paddr == OFS_DATA);
  assign sel_stat  = (paddr == OFS_STAT);
  assign sel_mask  = (paddr == OFS_MASK);
  assign sel_ctrl  = (paddr == OFS_CTRL);
  assign sel_buf   = ((paddr & BUF_AMSK) == OFS_BUF);
  assign hit       = |{sel_mode, sel_addr, sel_data, sel_stat, sel_mask,
                       sel_ctrl, sel_buf};
  assign acc_setup = psel & ~penable;
  assign acc_wr    = psel & penable & pwrite & hit;
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~hit;

  // readback view of the mode register with live busy
  always_comb begin
    mode_rd      = mode_reg;
    mode_rd.busy = busy;
  end

  // read multiplexer, unmapped reads zero
  always_comb begin
    rd_mux = '0;
    if (sel_mode) rd_mux[15:0] = mode_rd;
    if (sel_addr) rd_mux[15:0] = addr_reg;
    if (sel_data) rd_mux[7:0] = rdata_reg;
    if (sel_stat) rd_mux[0] = stat_reg;
    if (sel_mask) rd_mux[0] = mask_reg;
    if (sel_ctrl) rd_mux[CTRL_CS14] = cs14_reg;
    if (sel_buf) rd_mux[7:0] = wbuf_mem[paddr[3:2]];
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (acc_setup) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  // mode register, busy and reserved bits are not stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ppm_mode_type'(MODE_RESET);
    end else if (acc_wr && sel_mode) begin
      mode_reg <= ppm_mode_type'(pwdata[15:0] & MODE_WMASK);
    end
  end

  // control and mask registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs14_reg <= 1'b0;
      mask_reg <= 1'b0;
    end else begin
      if (acc_wr && sel_ctrl) cs14_reg <= pwdata[CTRL_CS14];
      if (acc_wr && sel_mask) mask_reg <= pwdata[0];
    end
  end

  // sticky event status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_reg <= 1'b0;
    end else begin
      stat_reg <= (stat_reg & ~(acc_wr & sel_stat & pwdata[0])) | irq_set;
    end
  end

  assign irq = stat_reg & mask_reg;

  // ----------------------------------------------------------------------
  // master sequencer
  // ----------------------------------------------------------------------
  assign master_on = mode_reg.port_mode[1];
  assign busy      = (state_reg != S_IDLE);
  assign go_wr     = acc_wr & sel_data & master_on;
  assign go_rd     = acc_wr & sel_ctrl & pwdata[CTRL_READ] & master_on;
  assign go        = (go_wr | go_rd) & ~busy;
  assign fast      = (mode_reg.strobe_wait_select == 4'h0);
  assign setup_cnt = fast ? 4'h0 : {2'h0, mode_reg.setup_wait_select};
  assign hold_len  = fast ? {3'h0, ~is_read_reg}
                          : {2'h0, mode_reg.hold_wait_select};
  assign xfer_end  = ((state_reg == S_STROBE) && (cnt_reg == 4'h0)
                      && (hold_len == 4'h0))
                   || ((state_reg == S_HOLD) && (cnt_reg == 4'h0));

  // setup, strobe and hold phases counted down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg   <= S_IDLE;
      cnt_reg     <= '0;
      is_read_reg <= 1'b0;
    end else begin
      case (state_reg)
        S_IDLE: begin
          if (go) begin
            state_reg   <= S_SETUP;
            cnt_reg     <= setup_cnt;
            is_read_reg <= go_rd;
          end
        end
        S_SETUP: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= S_STROBE;
            cnt_reg   <= mode_reg.strobe_wait_select;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        S_STROBE: begin
          if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if (hold_len == 4'h0) begin
            state_reg <= S_IDLE;
          end else begin
            state_reg <= S_HOLD;
            cnt_reg   <= hold_len - 4'h1;
          end
        end
        S_HOLD: begin
          if (cnt_reg == 4'h0) begin
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // master data and address registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_reg <= '0;
      rdata_reg <= '0;
      addr_reg  <= '0;
    end else begin
      if (go_wr && !busy) wdata_reg <= pwdata[7:0];
      if (xfer_end && is_read_reg) rdata_reg <= flt_reg.port_data_in;
      if (acc_wr && sel_addr && !busy) begin
        addr_reg <= pwdata[15:0];
      end else if (xfer_end) begin
        addr_reg <= ppm_step(addr_reg, mode_reg.address_step_select,
                             cs14_reg);
      end
    end
  end

  // ----------------------------------------------------------------------
  // slave port
  // ----------------------------------------------------------------------
  assign slave_on = ~mode_reg.port_mode[1];
  assign host_wr  = slave_on & flt_reg.chip_select_one & flt_reg.write_strobe;
  assign host_rd  = slave_on & flt_reg.chip_select_one & flt_reg.read_strobe;
  assign wr_rise  = host_wr & ~host_wr_prev_reg;
  assign rd_fall  = ~host_rd & host_rd_prev_reg;
  assign widx     = slv_index(wptr_reg, mode_reg,
                              flt_reg.port_address_lines);
  assign ridx     = slv_index(rptr_reg, mode_reg,
                              flt_reg.port_address_lines);

  // host strobe history and buffer pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_wr_prev_reg <= 1'b0;
      host_rd_prev_reg <= 1'b0;
      wptr_reg         <= '0;
      rptr_reg         <= '0;
    end else begin
      host_wr_prev_reg <= host_wr;
      host_rd_prev_reg <= host_rd;
      if (mode_reg.port_mode == PM_LEGACY
          && mode_reg.address_step_select == STEP_BUF) begin
        if (wr_rise) wptr_reg <= wptr_reg + 2'h1;
        if (rd_fall) rptr_reg <= rptr_reg + 2'h1;
      end
    end
  end

  // host writes fill one buffer set, software the other
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < BUF_COUNT; i++) begin
        wbuf_mem[i] <= '0;
        rbuf_mem[i] <= '0;
      end
    end else begin
      if (wr_rise) wbuf_mem[widx] <= flt_reg.port_data_in;
      if (acc_wr && sel_buf) rbuf_mem[paddr[3:2]] <= pwdata[7:0];
    end
  end

  // interrupt events from both master and slave cycles
  assign irq_set =
      ((mode_reg.interrupt_request_select == IRQ_CYCLE)
       && (xfer_end || wr_rise || rd_fall))
    || ((mode_reg.interrupt_request_select == IRQ_BUF3) && slave_on
       && ((wr_rise && widx == BUF_LAST)
           || (rd_fall && ridx == BUF_LAST)));

  // ----------------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------------
  // registered pins, one cycle behind the sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg <= '0;
    end else begin
      pins_reg <= '0;
      if (master_on) begin
        pins_reg.chip_select_one    <= busy;
        pins_reg.port_address_lines <= addr_reg;
        pins_reg.port_data_out      <= wdata_reg;
        pins_reg.port_data_oe       <= busy & ~is_read_reg;
        if (mode_reg.port_mode == PM_MSTR1) begin
          pins_reg.read_strobe   <= busy & is_read_reg;
          pins_reg.enable_strobe <= (state_reg == S_STROBE);
        end else begin
          pins_reg.read_strobe  <= (state_reg == S_STROBE)
                                   & is_read_reg;
          pins_reg.write_strobe <= (state_reg == S_STROBE)
                                   & ~is_read_reg;
        end
      end else begin
        pins_reg.port_data_out <= rbuf_mem[ridx];
        pins_reg.port_data_oe  <= host_rd;
      end
    end
  end

  assign pins_out = pins_reg;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  // strobe length seen so far, for the timing check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strb_len_reg <= '0;
    end else if (state_reg == S_STROBE) begin
      strb_len_reg <= strb_len_reg + 5'h01;
    end else begin
      strb_len_reg <= '0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  busy_on_start_a: assert property (go |=> mode_rd.busy)
    else $error("busy not set after start");
  irq_none_a: assert property (
    (mode_reg.interrupt_request_select == IRQ_NONE) |-> !irq_set)
    else $error("event raised with no source");
  irq_cycle_a: assert property (
    (xfer_end && mode_reg.interrupt_request_select == IRQ_CYCLE)
    |=> stat_reg) else $error("cycle end did not set status");
  irq_buf3_a: assert property (
    (wr_rise && widx == BUF_LAST
     && mode_reg.interrupt_request_select == IRQ_BUF3) |=> stat_reg)
    else $error("buffer three write did not set status");
  addr_inc_a: assert property (
    (xfer_end && mode_reg.address_step_select == STEP_INC && !cs14_reg)
    |=> {addr_reg[A14_BIT], addr_reg[ASTEP_HI:ASTEP_LO]}
        == $past({addr_reg[A14_BIT], addr_reg[ASTEP_HI:ASTEP_LO]})
           + 10'h001) else $error("address not incremented");
  addr_dec_a: assert property (
    (xfer_end && mode_reg.address_step_select == STEP_DEC && !cs14_reg)
    |=> {addr_reg[A14_BIT], addr_reg[ASTEP_HI:ASTEP_LO]}
        == $past({addr_reg[A14_BIT], addr_reg[ASTEP_HI:ASTEP_LO]})
           - 10'h001) else $error("address not decremented");
  addr_hold_a: assert property (
    (xfer_end && mode_reg.address_step_select == STEP_NONE)
    |=> $stable(addr_reg)) else $error("address moved with no step");
  buf_ptr_a: assert property (
    (wr_rise && mode_reg.port_mode == PM_LEGACY
     && mode_reg.address_step_select == STEP_BUF)
    |=> wptr_reg == $past(wptr_reg) + 2'h1)
    else $error("write pointer not advanced");
  a14_keep_a: assert property ((xfer_end && cs14_reg)
    |=> addr_reg[A14_BIT] == $past(addr_reg[A14_BIT]))
    else $error("select bit stepped");
  enable_pin_a: assert property (
    (state_reg == S_STROBE && mode_reg.port_mode == PM_MSTR1)
    |=> pins_out.enable_strobe && !pins_out.write_strobe)
    else $error("enable strobe missing");
  write_pin_a: assert property (
    (state_reg == S_STROBE && !is_read_reg
     && mode_reg.port_mode == PM_MSTR2) |=> pins_out.write_strobe)
    else $error("write strobe missing");
  setup_len_a: assert property (
    (go && !fast && mode_reg.setup_wait_select == 2'h3)
    |=> (state_reg == S_SETUP) [*4] ##1 (state_reg == S_STROBE))
    else $error("setup length wrong");
  strobe_len_a: assert property (
    (state_reg == S_STROBE && cnt_reg == 4'h0)
    |-> strb_len_reg == {1'b0, mode_reg.strobe_wait_select})
    else $error("strobe length wrong");
  fast_read_a: assert property (
    (go_rd && go && fast) |=> (state_reg == S_SETUP) ##1
    (state_reg == S_STROBE) ##1 (state_reg == S_IDLE))
    else $error("short read sequence wrong");
  busy_end_a: assert property (xfer_end |=> !mode_rd.busy)
    else $error("busy held after transfer");

  read_xfer_c: cover property (go_rd && go ##[1:40] xfer_end);
  write_hold_c: cover property (state_reg == S_HOLD ##1 !busy);
  slave_buf3_c: cover property (wr_rise && widx == BUF_LAST);
  irq_out_c: cover property ($rose(irq));

endmodule : ppm_port_ctrl

// file: shared/ppm_pkg.sv
// package: register map, field layout, pin carriers and sequencer states
package ppm_pkg;

  // ----------------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_CTRL = 8'h14;
  localparam logic [7:0] OFS_BUF  = 8'h20;
  localparam logic [7:0] BUF_AMSK = 8'hF3;

  // ----------------------------------------------------------------------
  // field values and positions
  // ----------------------------------------------------------------------
  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] MODE_WMASK = 16'h7BFF;
  localparam logic [1:0]  PM_LEGACY  = 2'h0;
  localparam logic [1:0]  PM_ENH     = 2'h1;
  localparam logic [1:0]  PM_MSTR2   = 2'h2;
  localparam logic [1:0]  PM_MSTR1   = 2'h3;
  localparam logic [1:0]  IRQ_NONE   = 2'h0;
  localparam logic [1:0]  IRQ_CYCLE  = 2'h1;
  localparam logic [1:0]  IRQ_BUF3   = 2'h2;
  localparam logic [1:0]  STEP_NONE  = 2'h0;
  localparam logic [1:0]  STEP_INC   = 2'h1;
  localparam logic [1:0]  STEP_DEC   = 2'h2;
  localparam logic [1:0]  STEP_BUF   = 2'h3;
  localparam logic [1:0]  BUF_LAST   = 2'h3;
  localparam int          BUF_COUNT  = 4;
  localparam int          CTRL_READ  = 0;
  localparam int          CTRL_CS14  = 1;
  localparam int          A14_BIT    = 14;
  localparam int          ASTEP_HI   = 10;
  localparam int          ASTEP_LO   = 2;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       busy;
    logic [1:0] interrupt_request_select;
    logic [1:0] address_step_select;
    logic       reserved;
    logic [1:0] port_mode;
    logic [1:0] setup_wait_select;
    logic [3:0] strobe_wait_select;
    logic [1:0] hold_wait_select;
  } ppm_mode_type;

  typedef struct packed {
    logic       chip_select_one;
    logic       read_strobe;
    logic       write_strobe;
    logic       enable_strobe;
    logic [15:0] port_address_lines;
    logic [7:0] port_data_out;
    logic       port_data_oe;
  } ppm_pin_out_type;

  typedef struct packed {
    logic       chip_select_one;
    logic       read_strobe;
    logic       write_strobe;
    logic [1:0] port_address_lines;
    logic [7:0] port_data_in;
  } ppm_pin_in_type;

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_STROBE, S_HOLD} ppm_state_type;

endpackage : ppm_pkg

// file: tb/ppm_ext_model.sv
// external memory and host model at the port pins
`timescale 1ns/1ps
module ppm_ext_model
  import ppm_pkg::*;
(
  // clock and bench control
  input  wire logic            pclk,
  input  wire logic            mode_one,
  input  wire logic            host_en,
  input  wire ppm_pin_in_type  host_in,
  // port pins
  input  wire ppm_pin_out_type pins_out,
  output ppm_pin_in_type       pins_in,
  // measured transfer
  output int                   strobe_w,
  output int                   select_w,
  output logic [7:0]           wr_byte,
  output logic [15:0]          wr_addr
);
  logic [7:0] mem [256];
  logic [7:0] last = 8'h00;
  int         sc   = 0;
  int         cc   = 0;
  logic       strb;
  logic       wrs;

  // strobe and write decode per master style
  assign strb = mode_one ? pins_out.enable_strobe
                         : pins_out.read_strobe | pins_out.write_strobe;
  assign wrs  = mode_one ? pins_out.enable_strobe & ~pins_out.read_strobe
                         : pins_out.write_strobe;

  // host drives slave modes; memory answers reads, else lines wander
  always_comb begin
    pins_in = host_en ? host_in : '0;
    if (!host_en)
      pins_in.port_data_in = (pins_out.chip_select_one && pins_out.read_strobe)
        ? mem[pins_out.port_address_lines[7:0]] : ~last;
  end

  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;

  // store written bytes and measure strobe and select widths
  always @(posedge pclk) begin
    last <= pins_in.port_data_in;
    if (pins_out.chip_select_one && wrs && !host_en) begin
      mem[pins_out.port_address_lines[7:0]] <= pins_out.port_data_out;
      wr_byte <= pins_out.port_data_out;
      wr_addr <= pins_out.port_address_lines;
    end
    if (strb) sc <= sc + 1;
    else if (sc != 0) begin
      strobe_w <= sc;
      sc <= 0;
    end
    if (pins_out.chip_select_one && !host_en) cc <= cc + 1;
    else if (cc != 0) begin
      select_w <= cc;
      cc <= 0;
    end
  end
endmodule : ppm_ext_model

// file: tb/ppm_port_ctrl_tb_top.sv
// self-checking bench: apb registers, master and slave port traffic
`timescale 1ns/1ps
module ppm_port_ctrl_tb_top;
  import ppm_pkg::*;
  logic            pclk, presetn, psel, penable, pwrite;
  logic            pready, pslverr, irq, mode_one, host_en, err_seen;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, rd_val;
  ppm_pin_in_type  host_in, pins_in;
  ppm_pin_out_type pins_out;
  int              strobe_w, select_w;
  int              error_cnt = 0;
  int              check_count = 0;
  logic [7:0]      wr_byte;
  logic [15:0]     wr_addr;

  ppm_port_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .pins_in(pins_in), .pins_out(pins_out));
  ppm_ext_model u_ext (.pclk(pclk), .mode_one(mode_one), .host_en(host_en),
    .host_in(host_in), .pins_out(pins_out), .pins_in(pins_in),
    .strobe_w(strobe_w), .select_w(select_w), .wr_byte(wr_byte),
    .wr_addr(wr_addr));

  // clock generator
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic final_report;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input string nm, input logic [31:0] exp, got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      error_cnt++;
      final_report();
    end
  endtask : bound

  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_val = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    bound(n, 20);
  endtask : apb

  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd_val);
  endtask : rchk

  function automatic logic [31:0] mk(input logic [1:0] iq, st, pm, sw,
                                     input logic [3:0] mw,
                                     input logic [1:0] hw);
    return {17'h0, iq, st, 1'b0, pm, sw, mw, hw};
  endfunction : mk

  // one master transfer with width, address and event checks
  task automatic master(input logic [31:0] mw, input logic rd, cs14,
                        input logic [15:0] a, ne, input int sw, cw);
    int n;
    logic [7:0] b;
    b = a[7:0] ^ 8'h3C;
    mode_one <= mw[8];
    apb(1'b1, OFS_MODE, mw);
    apb(1'b1, OFS_CTRL, {30'h0, cs14, 1'b0});
    apb(1'b1, OFS_ADDR, {16'h0, a});
    if (rd) apb(1'b1, OFS_CTRL, {30'h0, cs14, 1'b1});
    else apb(1'b1, OFS_DATA, {24'h0, b});
    rchk("busy", OFS_MODE, mw | 32'h8000);
    n = 0;
    do begin
      apb(1'b0, OFS_MODE, 32'h0);
      n++;
    end while (rd_val[15] !== 1'b0 && n < 40);
    bound(n, 40);
    chk("strobe width", sw, strobe_w);
    chk("select width", cw, select_w);
    rchk("next addr", OFS_ADDR, {16'h0, ne});
    if (rd) rchk("read byte", OFS_DATA, {24'h0, a[7:0] ^ 8'hA5});
    else chk("wr pins", {8'h0, a, b}, {8'h0, wr_addr, wr_byte});
    rchk("cycle event", OFS_STAT, {31'h0, mw[14:13] == IRQ_CYCLE});
    chk("irq", {31'h0, mw[14:13] == IRQ_CYCLE}, {31'h0, irq});
    apb(1'b1, OFS_STAT, 32'h1);
  endtask : master

  // host strobe on the slave pins, read answer kept in rd_val
  task automatic host(input logic w, input logic [1:0] a,
                      input logic [7:0] d);
    host_in <= '{1'b1, ~w, w, a, d};
    repeat (6) @(posedge pclk);
    rd_val = {23'h0, pins_out.port_data_oe, pins_out.port_data_out};
    host_in <= '{1'b0, 1'b0, 1'b0, a, ~d};
    repeat (6) @(posedge pclk);
  endtask : host

  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, mode_one, host_en} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    host_in = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk("mode reset", OFS_MODE, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err_seen});
    chk("unmapped data", 32'h0, rd_val);
    apb(1'b1, OFS_MODE, 32'hFFFFFFFF);
    rchk("mode mask", OFS_MODE, 32'h7BFF);
    apb(1'b1, OFS_MASK, 32'h1);
    master(mk(IRQ_CYCLE, STEP_INC, PM_MSTR2, 2'h1, 4'h7, 2'h2), 1'b0, 1'b0,
           16'h07FC, 16'h4000, 8, 12);
    master(mk(IRQ_NONE, STEP_DEC, PM_MSTR1, 2'h0, 4'hF, 2'h0), 1'b1, 1'b0,
           16'h4000, 16'h07FC, 16, 17);
    master(mk(IRQ_NONE, STEP_INC, PM_MSTR2, 2'h3, 4'h0, 2'h3), 1'b0, 1'b1,
           16'h47FC, 16'h4000, 1, 3);
    apb(1'b1, OFS_CTRL, 32'h3);
    repeat (4) @(posedge pclk);
    chk("fast rd select", 32'h2, select_w);
    chk("fast rd strobe", 32'h1, strobe_w);
    master(mk(IRQ_NONE, STEP_NONE, PM_MSTR1, 2'h3, 4'h3, 2'h1), 1'b0, 1'b0,
           16'h1234, 16'h1234, 4, 9);
    host_en <= 1'b1;
    apb(1'b1, OFS_MODE, mk(IRQ_BUF3, STEP_NONE, PM_ENH, 2'h0, 4'h0, 2'h0));
    apb(1'b1, OFS_BUF + 8'h04, 32'h66);
    host(1'b0, 2'h1, 8'h00);
    chk("host read", 32'h166, rd_val);
    host(1'b1, 2'h2, 8'h11);
    rchk("no event", OFS_STAT, 32'h0);
    host(1'b1, 2'h3, 8'h3C);
    rchk("buf3", OFS_BUF + 8'h0C, 32'h3C);
    chk("irq buf3", 32'h1, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MASK, 32'h1);
    apb(1'b1, OFS_STAT, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    apb(1'b1, OFS_MODE, mk(IRQ_NONE, STEP_BUF, PM_LEGACY, 2'h0, 4'h0, 2'h0));
    host(1'b1, 2'h3, 8'h21);
    host(1'b1, 2'h3, 8'h22);
    rchk("ptr buf0", OFS_BUF, 32'h21);
    rchk("ptr buf1", OFS_BUF + 8'h04, 32'h22);
    final_report();
  end
endmodule : ppm_port_ctrl_tb_top
